/* File: src/fps_sequencer.sv */
// Sequencing, hold and writeback control for the multiply and add pipes
// Functional notes
// - Integer and floating multiplies go to the multiply pipe, all other operations and integer divides to the add pipe.
// - Integer multiplies use only multiply stages two and three before the final stage.
// - Floating multiplies spend one clock in each of the four multiply stages before the final stage.
// - A floating multiply with both sources double stays two extra clocks in the entry stage after its sources are fetched.
// - While that double-by-double multiply is held, no further operation is accepted.
// - Non-divide add-pipe operations take one entry clock, or two with a double source, then one clock per add stage.
// - Divides stay 1 + R extra clocks in add stage two, R being 24 single, 32 integer, 53 double.
// - A divide stalls only the add pipe while the multiply pipe keeps moving.
// - A later add-pipe operation waits in the entry stage during a divide, which stalls issue.
// - The final stage checks imprecise exceptions and asks for a register-file writeback slot.
// - Final stage priority is integer multiply, then floating multiply, then the add pipe.
// - Double results make two passes through the final stage, one register per pass.
// - Each half of a double result is forwarded as it passes the final stage.
// - A double result costs one extra effective clock only when its consumer is strict.
// - Entry stage occupancy of one, two or four clocks sets the spacing to the next dispatch.
// - Unstalled latency is 5 for a single add, 6 for a single multiply, 4 for an integer multiply, 38 for an integer divide.
`timescale 1ns/1ps
`default_nettype none
`include "fps_defines.svh"

module fps_sequencer #(
  parameter int TAG_W = `FPS_TAG_W
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             dispatch_i,
  input  wire fps_pkg::fps_op_t op_class_i,
  input  wire logic             src_a_dbl_i,
  input  wire logic             src_b_dbl_i,
  input  wire logic             dst_dbl_i,
  input  wire logic             strict_use_i,
  input  wire logic [TAG_W-1:0] tag_i,
  input  wire logic             wb_grant_i,
  input  wire logic             fp_exc_i,
  output logic                  stall_o,
  output logic                  wb_req_o,
  output logic                  wb_half_o,
  output logic [TAG_W-1:0]      wb_tag_o,
  output logic                  fwd_o,
  output logic                  fwd_half_o,
  output logic                  done_o,
  output logic                  imp_exc_o,
  output logic [TAG_W-1:0]      res_tag_o
);
  import fps_pkg::*;

  typedef struct packed {
    logic             v;
    logic             imul;
    logic             dres;
    logic             strict;
    logic [TAG_W-1:0] tag;
  } fps_slot_t;

  typedef struct packed {
    fps_slot_t        ent;
    fps_op_t          ent_cls;
    logic [1:0]       ent_cnt;
    fps_slot_t        m1;
    fps_slot_t        m2;
    fps_slot_t        m3;
    fps_slot_t        m4;
    fps_slot_t        a2;
    logic             a2_div;
    logic [5:0]       div_cnt;
    fps_slot_t        a3;
    fps_slot_t        a4;
    fps_slot_t        fin;
    logic             fin_half;
    logic             fwd;
    logic             fwd_half;
    logic             done;
    logic             exc;
    logic [TAG_W-1:0] res_tag;
  } fps_state_t;

  fps_state_t st;
  fps_state_t next_st;

  logic c_imul, c_fmul, c_add, fin_leave, fin_take, g_imul, g_fmul, g_add;
  logic m4_free, m3_go, m3_free, m2_go, m2_free, m1_go, m1_free;
  logic a4_free, a3_go, a3_free, a2_go, a2_free;
  logic ent_is_mul, ent_is_imul, ent_go, ent_free, accept;

  always_comb begin
    // Final stage takeover and fixed-priority selection
    c_imul    = st.m3.v && st.m3.imul;
    c_fmul    = st.m4.v;
    c_add     = st.a4.v;
    fin_leave = st.fin.v && wb_grant_i && (!st.fin.dres || st.fin_half);
    fin_take  = !st.fin.v || fin_leave;
    g_imul    = fin_take && c_imul;
    g_fmul    = fin_take && c_fmul && !c_imul;
    g_add     = fin_take && c_add && !c_imul && !c_fmul;
    // Multiply pipe runs independently of any divide in progress
    m4_free = !st.m4.v || g_fmul;
    m3_go   = st.m3.v && (st.m3.imul ? g_imul : m4_free);
    m3_free = !st.m3.v || m3_go;
    m2_go   = st.m2.v && m3_free;
    m2_free = !st.m2.v || m2_go;
    m1_go   = st.m1.v && m2_free;
    m1_free = !st.m1.v || m1_go;
    // Add pipe
    a4_free = !st.a4.v || g_add;
    a3_go   = st.a3.v && a4_free;
    a3_free = !st.a3.v || a3_go;
    a2_go   = st.a2.v && (st.div_cnt == 6'h00) && a3_free;
    a2_free = !st.a2.v || a2_go;
    // Entry stage release
    ent_is_mul  = (st.ent_cls == FPS_OP_FMUL) || (st.ent_cls == FPS_OP_IMUL);
    ent_is_imul = st.ent_cls == FPS_OP_IMUL;
    ent_go = st.ent.v && (st.ent_cnt == 2'h0) &&
             (ent_is_imul ? (m2_free && !m1_go) :
              ent_is_mul  ? m1_free : a2_free);
    ent_free = !st.ent.v || ent_go;
    accept   = dispatch_i && ent_free;

    next_st = st;
    next_st.fwd  = 1'b0;
    next_st.done = 1'b0;
    next_st.exc  = 1'b0;

    // Final stage passes, forwarding and exception check
    if (st.fin.v && wb_grant_i) begin
      next_st.fwd      = 1'b1;
      next_st.fwd_half = st.fin_half;
      next_st.res_tag  = st.fin.tag;
      next_st.exc      = fp_exc_i && !st.fin_half;
      // Lenient consumers see the result after the first pass
      next_st.done = !st.fin.dres || (st.fin_half == st.fin.strict);
      if (st.fin.dres && !st.fin_half) begin
        next_st.fin_half = 1'b1;
      end
    end
    if (fin_take) begin
      next_st.fin.v    = 1'b0;
      next_st.fin_half = 1'b0;
      if (g_imul) begin
        next_st.fin = st.m3;
      end else if (g_fmul) begin
        next_st.fin = st.m4;
      end else if (g_add) begin
        next_st.fin = st.a4;
      end
    end

    // Multiply stages
    if (m4_free) begin
      next_st.m4 = (m3_go && !st.m3.imul) ? st.m3 : '0;
    end
    if (m3_free) begin
      next_st.m3 = m2_go ? st.m2 : '0;
    end
    if (m2_free) begin
      next_st.m2 = m1_go ? st.m1 :
                   (ent_go && ent_is_imul) ? st.ent : '0;
    end
    if (m1_free) begin
      next_st.m1 = (ent_go && st.ent_cls == FPS_OP_FMUL) ? st.ent : '0;
    end

    // Add stages, divide iteration in stage two
    if (a4_free) begin
      next_st.a4 = a3_go ? st.a3 : '0;
    end
    if (a3_free) begin
      next_st.a3 = a2_go ? st.a2 : '0;
    end
    if (st.a2.v && st.div_cnt != 6'h00) begin
      next_st.div_cnt = st.div_cnt - 6'h01;
    end
    if (a2_free) begin
      next_st.a2      = '0;
      next_st.a2_div  = 1'b0;
      next_st.div_cnt = 6'h00;
      if (ent_go && !ent_is_mul) begin
        next_st.a2     = st.ent;
        next_st.a2_div = st.ent_cls != FPS_OP_FADD;
        if (st.ent_cls == FPS_OP_IDIV) begin
          next_st.div_cnt = `FPS_DIV_EXTRA + `FPS_DIV_R_INT;
        end else if (st.ent_cls == FPS_OP_FDIV) begin
          next_st.div_cnt = `FPS_DIV_EXTRA + (st.ent.dres ? `FPS_DIV_R_DBL : `FPS_DIV_R_SGL);
        end
      end
    end

    // Entry stage: hold count covers double fetch and double-by-double hold
    if (st.ent.v && st.ent_cnt != 2'h0) begin
      next_st.ent_cnt = st.ent_cnt - 2'h1;
    end
    if (ent_free) begin
      next_st.ent.v   = 1'b0;
      next_st.ent_cnt = 2'h0;
      if (accept) begin
        next_st.ent.v      = 1'b1;
        next_st.ent.imul   = op_class_i == FPS_OP_IMUL;
        next_st.ent.dres   = dst_dbl_i && (op_class_i != FPS_OP_IMUL) && (op_class_i != FPS_OP_IDIV);
        next_st.ent.strict = strict_use_i;
        next_st.ent.tag    = tag_i;
        next_st.ent_cls    = op_class_i;
        next_st.ent_cnt    = ((src_a_dbl_i || src_b_dbl_i) ? `FPS_DBL_SRC_X : 2'h0) +
                             ((op_class_i == FPS_OP_FMUL && src_a_dbl_i && src_b_dbl_i) ?
                              `FPS_DD_HOLD : 2'h0);
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign stall_o    = st.ent.v && !ent_go;
  assign wb_req_o   = st.fin.v;
  assign wb_half_o  = st.fin_half;
  assign wb_tag_o   = st.fin.tag;
  assign fwd_o      = st.fwd;
  assign fwd_half_o = st.fwd_half;
  assign done_o     = st.done;
  assign imp_exc_o  = st.exc;
  assign res_tag_o  = st.res_tag;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  dd_hold_stall_a: assert property (st.ent.v && st.ent_cnt != 2'h0 |-> stall_o)
    else $error("entry hold without stall");
  imul_skip_a: assert property (!(st.m1.v && st.m1.imul) && !(st.m4.v && st.m4.imul))
    else $error("integer multiply in stage one or four");
  final_prio_a: assert property (fin_take && c_imul |=> st.fin.v && st.fin.imul)
    else $error("integer multiply lost final stage");
  div_load_a: assert property ($rose(st.a2_div) |-> st.div_cnt == 6'h19 || st.div_cnt == 6'h21 || st.div_cnt == 6'h36)
    else $error("bad divide iteration count");
  mul_runs_a: assert property (st.a2_div && st.div_cnt > 6'h01 && st.m1.v && !st.m2.v |=> st.m2.v)
    else $error("multiply pipe stalled by divide");
  div_block_a: assert property (st.a2.v && st.div_cnt > 6'h01 |=> st.a2.v && $stable(st.a2.tag))
    else $error("add stage two left during divide");
  dbl_pass_a: assert property (st.fin.v && st.fin.dres && !st.fin_half && wb_grant_i |=> st.fin.v && st.fin_half)
    else $error("double result skipped second pass");
  strict_late_a: assert property (st.fin.v && st.fin.dres && st.fin.strict && !st.fin_half && wb_grant_i |=> !done_o)
    else $error("strict double result released early");
  exc_check_a: assert property (st.fin.v && !st.fin_half && wb_grant_i && fp_exc_i |=> imp_exc_o && fwd_o)
    else $error("imprecise exception not reported");
  imul_lat_a: assert property (st.m2.v && st.m2.imul && !st.m3.v && !st.m4.v && !st.fin.v ##1 !st.m4.v && !st.fin.v |=> st.fin.v && st.fin.imul)
    else $error("integer multiply latency wrong");
endmodule : fps_sequencer
`default_nettype wire

/* File: src/fps_defines.svh */
// Timing and sizing constants for the floating-point pipeline sequencer
`ifndef FPS_DEFINES_SVH
`define FPS_DEFINES_SVH

`define FPS_DD_HOLD     2'h2
`define FPS_DBL_SRC_X   2'h1
`define FPS_DIV_R_SGL   6'h18
`define FPS_DIV_R_INT   6'h20
`define FPS_DIV_R_DBL   6'h35
`define FPS_DIV_EXTRA   6'h01
`define FPS_TAG_W       4

`endif

/* File: src/fps_pkg.sv */
// Types shared by the floating-point pipeline sequencer
`default_nettype none
package fps_pkg;
  typedef enum logic [2:0] {
    FPS_OP_FADD,
    FPS_OP_FDIV,
    FPS_OP_IDIV,
    FPS_OP_FMUL,
    FPS_OP_IMUL
  } fps_op_t;
endpackage : fps_pkg
`default_nettype wire

/* File: verification/fps_wb_arb.sv */
// Writeback slot arbiter model for the far side of the sequencer
`timescale 1ns/1ps
`default_nettype none
module fps_wb_arb (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic slow_i,
  output logic      grant_o
);
  // Slow mode offers a slot only every other clock
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) grant_o <= 1'b0;
    else grant_o <= slow_i ? ~grant_o : 1'b1;
  end
endmodule : fps_wb_arb
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the floating-point pipeline sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fps_pkg::*;
  logic            clk = 1'b0, rst = 1'b1, disp = 1'b0, sa = 1'b0, sb = 1'b0;
  logic            dd = 1'b0, strict = 1'b0, exc = 1'b0, slow = 1'b0, grant;
  fps_op_t         op = FPS_OP_FADD;
  logic [3:0]      tag = 4'h0, wtag, rtag;
  logic            stall, req, half, fwd, fhalf, done, iexc;
  int              failures = 0, num_checks = 0;

  always #25 clk = ~clk;

  fps_wb_arb arb (.clk_i(clk), .rst_i(rst), .slow_i(slow), .grant_o(grant));
  fps_sequencer uut (.clk_i(clk), .rst_i(rst), .dispatch_i(disp), .op_class_i(op), .src_a_dbl_i(sa),
    .src_b_dbl_i(sb), .dst_dbl_i(dd), .strict_use_i(strict), .tag_i(tag), .wb_grant_i(grant),
    .fp_exc_i(exc), .stall_o(stall), .wb_req_o(req), .wb_half_o(half), .wb_tag_o(wtag), .fwd_o(fwd),
    .fwd_half_o(fhalf), .done_o(done), .imp_exc_o(iexc), .res_tag_o(rtag));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // Drives one dispatch from a falling edge and returns one cycle later
  task automatic issue(input fps_op_t o, input logic a, b, d, s, input logic [3:0] t);
    op = o; sa = a; sb = b; dd = d; strict = s; tag = t; disp = 1'b1;
    chk("stall at dispatch", 8'h00, {7'h0, stall});
    @(negedge clk);
  endtask : issue

  task automatic run_op(input fps_op_t o, input logic a, b, d, s, x, input int lat, stl, dn);
    int n;
    int st;
    int m;
    issue(o, a, b, d, s, 4'h5);
    disp = 1'b0;
    exc = x;
    n = 0;
    st = 0;
    m = 1;
    while (req !== 1'b1 && n < 100) begin
      if (stall === 1'b1) st++;
      @(negedge clk);
      n++;
    end
    chk("write half", 8'h00, {7'h0, half});
    @(negedge clk);
    chk("forward", 8'h01, {7'h0, fwd});
    chk("forward half", 8'h00, {7'h0, fhalf});
    chk("second pass", {7'h0, d}, {7'h0, req & half});
    while (done !== 1'b1 && m < 4) begin
      @(negedge clk);
      m++;
    end
    chk("latency", 8'(lat - 1), 8'(n));
    chk("stall cycles", 8'(stl), 8'(st));
    chk("done delay", 8'(dn), 8'(m));
    chk("exception", {7'h0, x}, {7'h0, iexc});
    chk("result tag", 8'h05, {4'h0, rtag});
    exc = 1'b0;
    repeat (3) @(negedge clk);
  endtask : run_op

  task automatic t_add;
    run_op(FPS_OP_FADD, 0, 0, 0, 0, 1, 5, 0, 1);
    run_op(FPS_OP_FADD, 1, 0, 0, 0, 0, 6, 1, 1);
    run_op(FPS_OP_FDIV, 0, 0, 0, 0, 0, 30, 0, 1);
    run_op(FPS_OP_IDIV, 0, 0, 0, 0, 0, 38, 0, 1);
    run_op(FPS_OP_FDIV, 0, 0, 1, 0, 0, 59, 0, 1);
    $display("test add pipe done");
  endtask : t_add

  task automatic t_mul;
    run_op(FPS_OP_IMUL, 0, 0, 0, 0, 0, 4, 0, 1);
    run_op(FPS_OP_FMUL, 0, 0, 0, 0, 0, 6, 0, 1);
    run_op(FPS_OP_FMUL, 1, 1, 1, 0, 0, 9, 3, 1);
    run_op(FPS_OP_FMUL, 1, 1, 1, 1, 0, 9, 3, 2);
    $display("test multiply pipe done");
  endtask : t_mul

  task automatic t_div_mul;
    issue(FPS_OP_IDIV, 0, 0, 0, 0, 4'h1);
    issue(FPS_OP_IMUL, 0, 0, 0, 0, 4'h2);
    issue(FPS_OP_FMUL, 0, 0, 0, 0, 4'h6);
    disp = 1'b0;
    repeat (2) @(negedge clk);
    chk("mult request", 8'h01, {7'h0, req});
    chk("mult tag", 8'h02, {4'h0, wtag});
    repeat (3) @(negedge clk);
    chk("fmul request", 8'h01, {7'h0, req});
    chk("fmul tag", 8'h06, {4'h0, wtag});
    issue(FPS_OP_FADD, 0, 0, 0, 0, 4'h3);
    disp = 1'b0;
    @(negedge clk);
    chk("stall behind divide", 8'h01, {7'h0, stall});
    repeat (60) @(negedge clk);
    $display("test divide overlap done");
  endtask : t_div_mul

  task automatic t_prio;
    int n;
    slow = 1'b1;
    issue(FPS_OP_FADD, 0, 0, 0, 0, 4'h3);
    issue(FPS_OP_IMUL, 0, 0, 0, 0, 4'h4);
    disp = 1'b0;
    repeat (3) @(negedge clk);
    chk("first writeback tag", 8'h04, {4'h0, wtag});
    n = 0;
    while (!(done === 1'b1 && rtag === 4'h3) && n < 10) begin
      @(negedge clk);
      n++;
    end
    chk("add result late", 8'h01, {7'h0, done});
    slow = 1'b0;
    repeat (3) @(negedge clk);
    $display("test writeback priority done");
  endtask : t_prio

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  initial begin
    #100us;
    failures++;
    print_verdict();
  end

  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_add();
    t_mul();
    t_div_mul();
    t_prio();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
